// ### dspd_defines.svh
`ifndef DSPD_DEFINES_SVH
`define DSPD_DEFINES_SVH
//----------------------------------------------------------------------
// What this block does
// - Take 16-bit and 32-bit words, length first
// - Each instruction lands in exactly one group
// - MAC issues up to two moves, four ops
// - MAC takes one cycle, contention adds one
// - Dual MAC, ALU+BIT_MANIPULATION_UNIT, ADD_COMPARE_SELECT+adder combinations
// - Dual MAC adds on ALU, adder or both
// - Long MAC without moves runs conditionally
// - Special functions round, negate, abs, shift, conditional
// - Some special functions bump counters
// - ALU ops and operand forms incl. immediate
// - Long ALU may add adder op, conditional
// - Bit ops steered by accumulator, aux, immediate
// - Moves, loads, conditional, block and stack moves
// - Pointer arithmetic makes no memory access
// - Branch target absolute 20 or relative 12/16
// - Interrupt enable/disable, some controls conditional
// - Loop cache: 31 words, 65535 passes max
// - Five flags, only defined ones updated
// - Combined MAC takes flags from ALU, parity kept
// - Flag read-after-write register hazard
//----------------------------------------------------------------------
// Instruction field positions
`define DSPD_LEN 15
`define DSPD_GRP 14:12
`define DSPD_OP 11:8
`define DSPD_DST 7:4
`define DSPD_SRC 3:0
`define DSPD_MODE 7:6
`define DSPD_MDO 5:4
`define DSPD_MCB 3:2
`define DSPD_MAS 1:0
`define DSPD_CND 31:28
`define DSPD_CCC 7:4
`define DSPD_EXT 31:16
`define DSPD_APAR 27
`define DSPD_LLEN 4:0
`define DSPD_R12 11:0
// Limits and opcodes
`define DSPD_MAXXF 2'h2
`define DSPD_MAXBLK 31
`define DSPD_SF_INC 4'h5
`define DSPD_OP_LAST 4'h5
`define DSPD_CT_REL 4'h3
`define DSPD_CT_EI 4'h4
`define DSPD_CT_DI 4'h5
`define DSPD_MV_IMM 4'h2
`define DSPD_MV_CMV 4'h3
`define DSPD_MV_PTR 4'h7
`define DSPD_MD_IMM 2'h2
`define DSPD_MD_BAD 2'h3
// Flag bits: negative, zero, limit, math, parity
`define DSPD_FN 4
`define DSPD_FZ 3
`define DSPD_FL 2
`define DSPD_FM 1
`define DSPD_FE 0
`define DSPD_FM_ALL 5'h1F
`define DSPD_FM_NOPAR 5'h1E
`define DSPD_CC_ALW 4'h0
// Register map and reset values
`define DSPD_REG_CTRL 4'h0
`define DSPD_REG_FLAGS 4'h4
`define DSPD_REG_STAT 4'h8
`define DSPD_REG_LOOP 4'hC
`define DSPD_CTRL_RST 1'h1
`endif

// ### dspd_pkg.sv
package dspd_pkg;
  typedef enum logic [6:0] {
    GRP_NONE = 7'h00, GRP_MAC = 7'h01, GRP_SF = 7'h02, GRP_ALU = 7'h04,
    GRP_BMU = 7'h08, GRP_MOV = 7'h10, GRP_CTL = 7'h20, GRP_LC = 7'h40
  } dspd_grp_t;
  typedef enum logic [2:0] {
    LC_IDLE = 3'h1, LC_LOAD = 3'h2, LC_RUN = 3'h4
  } dspd_lc_t;
  typedef enum logic [2:0] {
    CB_NONE = 3'h0, CB_DUAL = 3'h1, CB_ALUBMU = 3'h2, CB_ACSADD = 3'h4
  } dspd_combo_t;
  typedef struct packed {
    logic valid;
    logic lng;
    dspd_grp_t grp;
    logic exec;
    logic [3:0] op;
    logic [3:0] dst;
    logic [3:0] src;
    logic [1:0] mode;
    logic [15:0] imm;
    logic [1:0] xfers;
    logic [2:0] dau_ops;
    dspd_combo_t combo;
    logic [1:0] addsel;
    logic apar;
    logic cnt_inc;
    logic mem;
    logic br;
    logic call;
    logic [19:0] tgt;
    logic extra;
    logic [4:0] fmask;
    logic wr;
    logic hazard;
  } dspd_dec_t;
endpackage

// ### dspd_flag_if.sv
`timescale 1ns/1ps
`default_nettype none
interface dspd_flag_if;
  logic issue;
  logic [4:0] mask;
  logic res_vld;
  logic [4:0] res;
  logic sw_we;
  logic [4:0] sw_val;
  logic [4:0] flags;
  modport dec (output issue, mask, res_vld, res, sw_we, sw_val,
               input flags);
  modport unit (input issue, mask, res_vld, res, sw_we, sw_val,
                output flags);
endinterface
`default_nettype wire

// ### dspd_flag_unit.sv
`timescale 1ns/1ps
`default_nettype none
`include "dspd_defines.svh"
module dspd_flag_unit (
  input wire logic clk,
  input wire logic reset,
  dspd_flag_if.unit fl
);
  logic [4:0] pend_r;
  logic [4:0] flags_r;
  logic [4:0] upd;

  //--------------------------------------------------------------------
  // Flag register
  //--------------------------------------------------------------------
  // Mask of the last issued instruction, waits for its result
  always_ff @(posedge clk) begin
    if (reset) begin
      pend_r <= 5'h00;
    end else if (fl.issue) begin
      pend_r <= fl.mask;
    end else if (fl.res_vld) begin
      pend_r <= 5'h00;
    end
  end

  assign upd = fl.res_vld ? pend_r : 5'h00;

  // Software load first, result bits on top so hardware wins
  always_ff @(posedge clk) begin
    if (reset) begin
      flags_r <= 5'h00;
    end else begin
      flags_r <= ((fl.sw_we ? fl.sw_val : flags_r) & ~upd)
                 | (fl.res & upd);
    end
  end

  assign fl.flags = flags_r;

  property p_keep;
    @(posedge clk) disable iff (reset)
    fl.res_vld && !fl.sw_we |=>
      ((flags_r ^ $past(flags_r)) & ~$past(pend_r)) == 5'h00;
  endproperty
  a_keep: assert property (p_keep)
    else $error("unmasked flag changed");
endmodule
`default_nettype wire

// ### dspd_decoder.sv
// Register access over Avalon-MM and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "dspd_defines.svh"
module dspd_decoder
  import dspd_pkg::*;
#(
  parameter int MAX_BLK = `DSPD_MAXBLK
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic instr_valid,
  output logic instr_ready,
  input wire logic [31:0] instr_word,
  input wire logic [19:0] instr_pc,
  input wire logic res_valid,
  input wire logic [4:0] res_flags,
  output logic dec_valid,
  output logic dec_long,
  output logic [6:0] dec_group,
  output logic dec_exec,
  output logic [3:0] dec_op,
  output logic [3:0] dec_dst,
  output logic [3:0] dec_src,
  output logic [1:0] dec_mode,
  output logic [15:0] dec_imm,
  output logic [1:0] mac_xfers,
  output logic [2:0] mac_dau_ops,
  output logic [2:0] mac_combo,
  output logic [1:0] mac_addsel,
  output logic alu_adder_par,
  output logic sf_count_inc,
  output logic mov_mem_access,
  output logic br_valid,
  output logic br_call,
  output logic [19:0] br_target,
  output logic dec_extra,
  output logic [4:0] dec_flag_mask,
  output logic dec_hazard,
  output logic int_enable,
  output logic loop_active,
  output logic [4:0] flags,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);
  if (MAX_BLK < 1 || MAX_BLK > `DSPD_MAXBLK) begin : g_chk
    $error("MAX_BLK out of range");
  end

  dspd_flag_if fl ();
  dspd_flag_unit u_flags (
    .clk(clk),
    .reset(reset),
    .fl(fl)
  );

  dspd_dec_t d;
  dspd_dec_t dec_r;
  dspd_grp_t g;
  dspd_lc_t lc_r;
  dspd_lc_t lc_nxt;
  logic [31:0] w;
  logic [19:0] pc;
  logic [3:0] cnd;
  logic ok;
  logic ex;
  logic src_vld;
  logic ready_r;
  logic ctrl_en_r;
  logic int_en_r;
  logic waitreq_r;
  logic [31:0] rdata_r;
  logic bus_wr;
  logic lc_go;
  logic last_wr;
  logic last_rd;
  logic loop_act_r;
  logic [4:0] blk_r;
  logic [15:0] iter_r;
  logic [4:0] widx_r;
  logic [4:0] ridx_r;
  logic [51:0] ent_w [MAX_BLK];

  //--------------------------------------------------------------------
  // Condition evaluation
  //--------------------------------------------------------------------
  function automatic logic cond_true(input logic [3:0] c,
                                     input logic [4:0] f);
    case (c)
      `DSPD_CC_ALW: cond_true = 1'b1;
      4'h1: cond_true = f[`DSPD_FN];
      4'h2: cond_true = !f[`DSPD_FN];
      4'h3: cond_true = f[`DSPD_FZ];
      4'h4: cond_true = !f[`DSPD_FZ];
      4'h5: cond_true = f[`DSPD_FL];
      4'h6: cond_true = f[`DSPD_FM];
      4'h7: cond_true = f[`DSPD_FE];
      default: cond_true = 1'b0;
    endcase
  endfunction

  //--------------------------------------------------------------------
  // Instruction source
  //--------------------------------------------------------------------
  // Replay from cache while looping, else from fetch
  assign src_vld = (lc_r == LC_RUN) || (instr_valid && ready_r);
  assign w = (lc_r == LC_RUN) ? ent_w[ridx_r][31:0] : instr_word;
  assign pc = (lc_r == LC_RUN) ? ent_w[ridx_r][51:32] : instr_pc;

  //--------------------------------------------------------------------
  // Decode
  //--------------------------------------------------------------------
  always_comb begin
    d = '0;
    ok = 1'b0;
    g = dspd_grp_t'(7'(7'h01 << w[`DSPD_GRP]));
    d.valid = src_vld;
    d.lng = w[`DSPD_LEN];
    d.grp = g;
    d.op = w[`DSPD_OP];
    d.dst = w[`DSPD_DST];
    d.src = w[`DSPD_SRC];
    d.mode = w[`DSPD_MODE];
    d.imm = d.lng ? w[`DSPD_EXT] : 16'h0000;
    cnd = d.lng ? w[`DSPD_CND] : `DSPD_CC_ALW;
    case (g)
      GRP_MAC: begin
        d.xfers = w[`DSPD_MODE];
        d.dau_ops = {1'b0, w[`DSPD_MDO]} + 3'h1;
        d.addsel = w[`DSPD_MAS];
        case (w[`DSPD_MCB])
          2'h0: d.combo = CB_DUAL;
          2'h1: d.combo = CB_ALUBMU;
          2'h2: d.combo = CB_ACSADD;
          default: d.combo = CB_NONE;
        endcase
        ok = d.xfers <= `DSPD_MAXXF && d.combo != CB_NONE
             && (d.combo != CB_DUAL || d.addsel != 2'h0);
        if (!d.lng || d.xfers != 2'h0) begin
          cnd = `DSPD_CC_ALW;
        end
        d.fmask = d.lng ? `DSPD_FM_ALL : `DSPD_FM_NOPAR;
        if (d.combo != CB_DUAL) begin
          d.fmask = `DSPD_FM_NOPAR;
        end
        d.extra = d.xfers == `DSPD_MAXXF;
      end
      GRP_SF: begin
        ok = d.op <= `DSPD_OP_LAST;
        if (!d.lng) begin
          cnd = w[`DSPD_SRC];
        end
        d.cnt_inc = d.op == `DSPD_SF_INC;
        d.fmask = `DSPD_FM_ALL;
        d.wr = 1'b1;
      end
      GRP_ALU: begin
        ok = !d.op[3] && d.mode != `DSPD_MD_BAD
             && (d.lng || d.mode != `DSPD_MD_IMM);
        if (d.mode == `DSPD_MD_IMM) begin
          cnd = `DSPD_CC_ALW;
        end
        d.apar = d.lng && d.mode != `DSPD_MD_IMM
                 && w[`DSPD_APAR];
        d.fmask = `DSPD_FM_ALL;
        d.wr = 1'b1;
      end
      GRP_BMU: begin
        ok = d.op <= `DSPD_OP_LAST && d.mode != `DSPD_MD_BAD
             && (d.lng || d.mode != `DSPD_MD_IMM);
        if (d.mode == `DSPD_MD_IMM) begin
          cnd = `DSPD_CC_ALW;
        end
        d.fmask = `DSPD_FM_ALL;
        d.wr = 1'b1;
      end
      GRP_MOV: begin
        ok = d.lng || (d.op != `DSPD_MV_IMM && d.op != `DSPD_MV_CMV);
        if (d.op != `DSPD_MV_CMV) begin
          cnd = `DSPD_CC_ALW;
        end
        d.mem = d.op == 4'h1 || d.op == 4'h4
                || d.op == 4'h5 || d.op == 4'h6;
        d.wr = d.op != `DSPD_MV_PTR && d.op != 4'h1;
      end
      GRP_CTL: begin
        if (!d.lng) begin
          ok = 1'b1;
          d.br = 1'b1;
          d.tgt = pc + {{8{w[11]}}, w[`DSPD_R12]};
        end else begin
          ok = d.op <= `DSPD_OP_LAST;
          cnd = w[`DSPD_CCC];
          d.br = d.op <= `DSPD_CT_REL;
          d.call = d.op[0] && d.op <= `DSPD_CT_REL;
          d.tgt = d.op[1] ? pc + {{4{w[31]}}, w[`DSPD_EXT]}
                          : {w[`DSPD_SRC], w[`DSPD_EXT]};
        end
      end
      GRP_LC: begin
        ok = d.lng && lc_r == LC_IDLE && w[`DSPD_EXT] != 16'h0000
             && w[`DSPD_LLEN] != 5'h00
             && w[`DSPD_LLEN] <= 5'(MAX_BLK);
        cnd = `DSPD_CC_ALW;
      end
      default: ok = 1'b0;
    endcase
    ex = cond_true(cnd, fl.flags);
    d.hazard = src_vld && dec_r.valid && dec_r.wr
               && d.src == dec_r.dst;
    if (!ok) begin
      d = '0;
      d.valid = src_vld;
    end else begin
      d.exec = ex;
      if (!ex) begin
        d.fmask = 5'h00;
        d.br = 1'b0;
        d.call = 1'b0;
        d.cnt_inc = 1'b0;
        d.wr = 1'b0;
      end
    end
  end

  assign lc_go = d.valid && d.exec && d.grp == GRP_LC;

  // Decode stage register
  always_ff @(posedge clk) begin
    if (reset) begin
      dec_r <= '0;
    end else begin
      dec_r <= d;
    end
  end

  // Global interrupt enable from control words
  always_ff @(posedge clk) begin
    if (reset) begin
      int_en_r <= 1'b0;
    end else if (d.valid && d.exec && d.grp == GRP_CTL && d.lng) begin
      if (d.op == `DSPD_CT_EI) begin
        int_en_r <= 1'b1;
      end else if (d.op == `DSPD_CT_DI) begin
        int_en_r <= 1'b0;
      end
    end
  end

  //--------------------------------------------------------------------
  // Loop cache
  //--------------------------------------------------------------------
  assign last_wr = widx_r == 5'(blk_r - 5'h01);
  assign last_rd = ridx_r == 5'(blk_r - 5'h01);

  always_comb begin
    lc_nxt = lc_r;
    case (lc_r)
      LC_IDLE: begin
        if (lc_go) begin
          lc_nxt = LC_LOAD;
        end
      end
      LC_LOAD: begin
        if (src_vld && last_wr) begin
          lc_nxt = (iter_r == 16'h0001) ? LC_IDLE : LC_RUN;
        end
      end
      LC_RUN: begin
        if (last_rd && iter_r == 16'h0001) begin
          lc_nxt = LC_IDLE;
        end
      end
      default: lc_nxt = LC_IDLE;
    endcase
  end

  // Block length, passes left and indices
  always_ff @(posedge clk) begin
    if (reset) begin
      lc_r <= LC_IDLE;
      blk_r <= 5'h00;
      iter_r <= 16'h0000;
      widx_r <= 5'h00;
      ridx_r <= 5'h00;
    end else begin
      lc_r <= lc_nxt;
      case (lc_r)
        LC_IDLE: begin
          if (lc_go) begin
            blk_r <= w[`DSPD_LLEN];
            iter_r <= w[`DSPD_EXT];
            widx_r <= 5'h00;
            ridx_r <= 5'h00;
          end
        end
        LC_LOAD: begin
          if (src_vld) begin
            widx_r <= widx_r + 5'h01;
            if (last_wr) begin
              iter_r <= iter_r - 16'h0001;
            end
          end
        end
        LC_RUN: begin
          ridx_r <= last_rd ? 5'h00 : ridx_r + 5'h01;
          if (last_rd) begin
            iter_r <= iter_r - 16'h0001;
          end
        end
        default: ;
      endcase
    end
  end

  // Cache entries hold word and its address
  for (genvar i = 0; i < MAX_BLK; i++) begin : g_ent
    logic [51:0] ent_r;
    always_ff @(posedge clk) begin
      if (reset) begin
        ent_r <= '0;
      end else if (lc_r == LC_LOAD && src_vld && widx_r == 5'(i)) begin
        ent_r <= {instr_pc, instr_word};
      end
    end
    assign ent_w[i] = ent_r;
  end

  // Fetch is held off while the cache replays
  always_ff @(posedge clk) begin
    if (reset) begin
      ready_r <= 1'b0;
    end else begin
      ready_r <= ctrl_en_r && lc_nxt != LC_RUN;
    end
  end

  // Loop busy flag follows the next cache state
  always_ff @(posedge clk) begin
    if (reset) begin
      loop_act_r <= 1'b0;
    end else begin
      loop_act_r <= lc_nxt != LC_IDLE;
    end
  end

  //--------------------------------------------------------------------
  // Flag unit hookup
  //--------------------------------------------------------------------
  assign fl.issue = dec_r.valid && dec_r.exec;
  assign fl.mask = dec_r.fmask;
  assign fl.res_vld = res_valid;
  assign fl.res = res_flags;
  assign fl.sw_we = bus_wr && avs_address == `DSPD_REG_FLAGS
                    && avs_byteenable[0];
  assign fl.sw_val = avs_writedata[4:0];

  //--------------------------------------------------------------------
  // Avalon slave
  //--------------------------------------------------------------------
  assign bus_wr = avs_write && !waitreq_r;

  // One wait state per access
  always_ff @(posedge clk) begin
    if (reset) begin
      waitreq_r <= 1'b1;
    end else if ((avs_read || avs_write) && waitreq_r) begin
      waitreq_r <= 1'b0;
    end else begin
      waitreq_r <= 1'b1;
    end
  end

  // Read data ready at the edge that ends the wait
  always_ff @(posedge clk) begin
    if (reset) begin
      rdata_r <= 32'h0000_0000;
    end else if (avs_read && waitreq_r) begin
      case (avs_address)
        `DSPD_REG_CTRL: rdata_r <= {31'h0, ctrl_en_r};
        `DSPD_REG_FLAGS: rdata_r <= {27'h0, fl.flags};
        `DSPD_REG_STAT: rdata_r <= {28'h0, int_en_r, lc_r};
        `DSPD_REG_LOOP: rdata_r <= {11'h0, blk_r, iter_r};
        default: rdata_r <= 32'h0000_0000;
      endcase
    end
  end

  // Decode enable
  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl_en_r <= `DSPD_CTRL_RST;
    end else if (bus_wr && avs_address == `DSPD_REG_CTRL
                 && avs_byteenable[0]) begin
      ctrl_en_r <= avs_writedata[0];
    end
  end

  //--------------------------------------------------------------------
  // Outputs
  //--------------------------------------------------------------------
  assign instr_ready = ready_r;
  assign dec_valid = dec_r.valid;
  assign dec_long = dec_r.lng;
  assign dec_group = dec_r.grp;
  assign dec_exec = dec_r.exec;
  assign dec_op = dec_r.op;
  assign dec_dst = dec_r.dst;
  assign dec_src = dec_r.src;
  assign dec_mode = dec_r.mode;
  assign dec_imm = dec_r.imm;
  assign mac_xfers = dec_r.xfers;
  assign mac_dau_ops = dec_r.dau_ops;
  assign mac_combo = dec_r.combo;
  assign mac_addsel = dec_r.addsel;
  assign alu_adder_par = dec_r.apar;
  assign sf_count_inc = dec_r.cnt_inc;
  assign mov_mem_access = dec_r.mem;
  assign br_valid = dec_r.br;
  assign br_call = dec_r.call;
  assign br_target = dec_r.tgt;
  assign dec_extra = dec_r.extra;
  assign dec_flag_mask = dec_r.fmask;
  assign dec_hazard = dec_r.hazard;
  assign int_enable = int_en_r;
  assign loop_active = loop_act_r;
  assign flags = fl.flags;
  assign avs_readdata = rdata_r;
  assign avs_waitrequest = waitreq_r;

  //--------------------------------------------------------------------
  // Checks
  //--------------------------------------------------------------------
  sequence s_take;
    instr_valid && instr_ready && lc_r != LC_RUN;
  endsequence
  sequence s_loopgo;
    lc_r == LC_IDLE && lc_go;
  endsequence

  property p_len;
    @(posedge clk) disable iff (reset)
    s_take |=> dec_valid && (dec_group == 7'h00
      || dec_long == $past(instr_word[`DSPD_LEN]));
  endproperty
  a_len: assert property (p_len)
    else $error("length bit not carried");

  property p_grp;
    @(posedge clk) disable iff (reset)
    s_take |=> dec_group == 7'h00
      || dec_group == 7'(7'h01 << $past(instr_word[`DSPD_GRP]));
  endproperty
  a_grp: assert property (p_grp)
    else $error("group does not match word");

  property p_mac;
    @(posedge clk) disable iff (reset)
    dec_valid && dec_group == GRP_MAC |->
      mac_xfers <= 2'h2 && mac_dau_ops inside {[3'h1:3'h4]}
      && dec_extra == (mac_xfers == 2'h2);
  endproperty
  a_mac: assert property (p_mac)
    else $error("MAC transfer or op count wrong");

  property p_gate;
    @(posedge clk) disable iff (reset)
    dec_valid && !dec_exec |-> dec_flag_mask == 5'h00 && !br_valid;
  endproperty
  a_gate: assert property (p_gate)
    else $error("skipped instruction still acts");

  property p_par;
    @(posedge clk) disable iff (reset)
    dec_valid && dec_group == GRP_MAC && mac_combo != CB_DUAL |->
      dec_flag_mask == (dec_exec ? 5'h1E : 5'h00);
  endproperty
  a_par: assert property (p_par)
    else $error("combined MAC flag mask wrong");

  property p_ptr;
    @(posedge clk) disable iff (reset)
    dec_valid && dec_group == GRP_MOV && dec_op == 4'h7
      |-> !mov_mem_access;
  endproperty
  a_ptr: assert property (p_ptr)
    else $error("pointer arithmetic touched memory");

  property p_br12;
    @(posedge clk) disable iff (reset)
    s_take ##1 (dec_group == GRP_CTL && !dec_long && br_valid) |->
      br_target == 20'($past(instr_pc)
                   + {{8{$past(instr_word[11])}}, $past(instr_word[11:0])});
  endproperty
  a_br12: assert property (p_br12)
    else $error("relative target wrong");

  property p_loop;
    @(posedge clk) disable iff (reset)
    s_loopgo |=> lc_r == LC_LOAD && instr_ready == $past(ctrl_en_r)
      && blk_r == $past(instr_word[`DSPD_LLEN])
      && iter_r == $past(instr_word[`DSPD_EXT]);
  endproperty
  a_loop: assert property (p_loop)
    else $error("loop cache start wrong");

  property p_nop;
    @(posedge clk) disable iff (reset)
    s_take and (instr_word[`DSPD_GRP] == 3'h7) |=>
      dec_group == 7'h00 && !dec_exec && dec_flag_mask == 5'h00;
  endproperty
  a_nop: assert property (p_nop)
    else $error("undefined word not a no-op");
endmodule
`default_nettype wire

// ### dspd_fetch_model.sv
`timescale 1ns/1ps
`default_nettype none
module dspd_fetch_model (
  input wire logic clk,
  input wire logic reset,
  input wire logic go,
  input wire logic [31:0] w,
  input wire logic [19:0] pc,
  input wire logic [4:0] rf,
  input wire logic instr_ready,
  input wire logic dec_valid,
  input wire logic dec_exec,
  output logic instr_valid,
  output logic [31:0] instr_word,
  output logic [19:0] instr_pc,
  output logic res_valid,
  output logic [4:0] res_flags
);
  //--------------------------------------------
  // Fetch side
  //--------------------------------------------
  // Offer one word, hold until taken, scramble when idle
  always_ff @(posedge clk) begin
    if (reset) begin
      instr_valid <= 1'b0;
      instr_word <= 32'h0;
      instr_pc <= 20'h0;
    end else if (go) begin
      instr_valid <= 1'b1;
      instr_word <= w;
      instr_pc <= pc;
    end else if (instr_valid && instr_ready) begin
      instr_valid <= 1'b0;
      instr_word <= ~instr_word;
      instr_pc <= ~instr_pc;
    end else if (!instr_valid) begin
      instr_word <= ~instr_word;
    end
  end
  //--------------------------------------------
  // Execution side
  //--------------------------------------------
  // Result flags one cycle after an executed decode
  always_ff @(posedge clk) begin
    if (reset) begin
      res_valid <= 1'b0;
      res_flags <= 5'h0;
    end else begin
      res_valid <= dec_valid && dec_exec;
      res_flags <= (dec_valid && dec_exec) ? rf : ~res_flags;
    end
  end
endmodule
`default_nettype wire

// ### dsp_core_instruction_group_decoder_tb.sv
`timescale 1ns/1ps
`default_nettype none
module dsp_core_instruction_group_decoder_tb;
  import dspd_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic go = 1'b0;
  logic [31:0] w = 32'h0;
  logic [19:0] pc = 20'h0;
  logic [4:0] rf = 5'h0;
  logic instr_valid, instr_ready, res_valid, dec_valid, dec_long, dec_exec;
  logic [31:0] instr_word, rd;
  logic [19:0] instr_pc, br_target;
  logic [4:0] res_flags, dec_flag_mask, flags;
  logic [6:0] dec_group;
  logic sf_count_inc, mov_mem_access, br_valid, int_enable, loop_active;
  logic br_call, dec_hazard;
  logic [15:0] dec_imm;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  int fail_count = 0;
  int n_tests = 0;
  int n_dec = 0;
  int n_haz = 0;
  int cyc = 0;
  int n0;
  logic [31:0] tw [8] = '{32'h0015, 32'h1500, 32'h2123, 32'h3000,
                          32'h4100, 32'h5010, 32'h7000, 32'h00C5};
  logic [6:0] tg [8] = '{7'h01, 7'h02, 7'h04, 7'h08, 7'h10, 7'h20, 7'h00,
                         7'h00};
  always #2 clk = ~clk;
  dspd_decoder i_dspd_decoder (.clk(clk), .reset(reset),
    .instr_valid(instr_valid), .instr_ready(instr_ready),
    .instr_word(instr_word), .instr_pc(instr_pc), .res_valid(res_valid),
    .res_flags(res_flags), .dec_valid(dec_valid), .dec_long(dec_long),
    .dec_group(dec_group), .dec_exec(dec_exec), .dec_op(), .dec_dst(),
    .dec_src(), .dec_mode(), .dec_imm(dec_imm), .mac_xfers(), .mac_dau_ops(),
    .mac_combo(), .mac_addsel(), .alu_adder_par(),
    .sf_count_inc(sf_count_inc), .mov_mem_access(mov_mem_access),
    .br_valid(br_valid), .br_call(br_call), .br_target(br_target),
    .dec_extra(), .dec_flag_mask(dec_flag_mask),
    .dec_hazard(dec_hazard), .int_enable(int_enable),
    .loop_active(loop_active), .flags(flags), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(4'hF),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));
  dspd_fetch_model i_dspd_fetch_model (.clk(clk), .reset(reset), .go(go),
    .w(w), .pc(pc), .rf(rf), .instr_ready(instr_ready),
    .dec_valid(dec_valid), .dec_exec(dec_exec), .instr_valid(instr_valid),
    .instr_word(instr_word), .instr_pc(instr_pc), .res_valid(res_valid),
    .res_flags(res_flags));
  // Decode counter and run limit
  always @(posedge clk) begin
    if (dec_valid === 1'b1) n_dec++;
    if (dec_hazard === 1'b1) n_haz++;
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, e);
    n_tests++;
    if (s !== e) begin
      fail_count++;
      $display("BAD %s exp %h seen %h", nm, e, s);
    end
  endtask
  // Bus cycle: hold until waitrequest sampled low
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  // Offer one word and stop where its decode stands
  task automatic send(input logic [31:0] wd);
    int n;
    @(posedge clk);
    go <= 1'b1;
    w <= wd;
    pc <= 20'h00100;
    @(posedge clk);
    go <= 1'b0;
    #1;
    for (n = 0; n < 50 && dec_valid !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    chk("dec_valid", dec_valid, 1);
  endtask
  //--------------------------------------------
  // Main sequence
  //--------------------------------------------
  initial begin
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    bus(0, 4'h0, 0); chk("ctrl", rd, 1);
    bus(0, 4'h4, 0); chk("flags", rd, 0);
    bus(0, 4'h8, 0); chk("stat", rd, 1);
    bus(0, 4'hC, 0); chk("loop", rd, 0);
    bus(0, 4'h2, 0); chk("unmapped", rd, 0);
    $display("test registers done");
    for (int i = 0; i < 8; i++) begin
      send(tw[i]);
      chk("group", dec_group, tg[i]);
      chk("exec", dec_exec, tg[i] != 0);
      chk("long", dec_long, 0);
      case (i)
        1: chk("count", sf_count_inc, 1);
        4: chk("mem", mov_mem_access, 1);
        5: chk("rel12", br_target, 20'h00110);
        default: ;
      endcase
    end
    $display("test groups done");
    send(32'h1234_D005);
    chk("long", dec_long, 1);
    chk("abs", br_target, 20'h51234);
    chk("imm", dec_imm, 16'h1234);
    send(32'hFFF0_D300);
    chk("call", br_call, 1);
    chk("rel16", br_target, 20'h000F0);
    send(32'hF000_A100);
    chk("never", dec_exec, 0);
    chk("mask", dec_flag_mask, 0);
    send(32'h0000_D400);
    bus(0, 4'h8, 0); chk("ei", rd[3], 1);
    send(32'h0000_D500);
    bus(0, 4'h8, 0); chk("di", int_enable, 0);
    $display("test control done");
    rf <= 5'h1F;
    send(32'h0015);
    repeat (2) @(posedge clk);
    bus(0, 4'h4, 0); chk("macflags", rd, 32'h1E);
    bus(1, 4'h4, 32'h01);
    send(32'h4000);
    bus(0, 4'h4, 0); chk("kept", flags, 5'h01);
    $display("test flags done");
    bus(1, 4'h0, 0);
    @(posedge clk);
    #1 chk("ready", instr_ready, 0);
    bus(1, 4'h0, 1);
    n0 = n_dec;
    send(32'h0003_E002);
    send(32'h2123);
    send(32'h2132);
    for (int n = 0; n < 100 && loop_active !== 1'b0; n++) @(posedge clk);
    repeat (2) @(posedge clk);
    chk("passes", n_dec - n0, 7);
    chk("hazard", n_haz, 4);
    bus(0, 4'h8, 0); chk("idle", rd, 1);
    $display("test loop done");
    report_and_stop();
  end
endmodule
`default_nettype wire
